// ===== camera_controller_end.sv
// Purpose: camera controller end: APB registers, master clock, reset and pixel capture
// Assumes: APB3 with zero wait states
// Notes: window, size, granularity and subsampling settings apply at the sensor's next frame start; levels and gain apply at once
`timescale 1ns/1ps
`default_nettype none
module camera_controller_end
  import image_readout_pkg::*;
#(
  parameter int PIX_DIV = MASTER_DIV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // captured pixel stream
  output logic [PIX_W-1:0] pixelOut,
  output logic pixelOutValid,
  output logic frameActive,
  // link to the sensor
  image_readout_if.controller link
);
  if (PIX_DIV < 1 || PIX_DIV > 255) begin : gBadDiv
    $error("PIX_DIV must be 1 to 255");
  end

  logic [31:0] ctrl_q;
  logic [31:0] window_q;
  logic [31:0] size_q;
  logic [31:0] level_q;
  logic [15:0] frameCount_q;
  logic frameSeen_q;
  logic [7:0] divCnt_q;
  logic [PIX_W-1:0] pixelOut_q;
  logic pixelOutValid_q;
  logic wrEn;
  logic mapped;
  logic [31:0] rdData;

  assign wrEn = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    if (paddr == CTRL_ADDR) begin
      rdData = ctrl_q;
    end else if (paddr == WINDOW_ADDR) begin
      rdData = window_q;
    end else if (paddr == SIZE_ADDR) begin
      rdData = size_q;
    end else if (paddr == LEVEL_ADDR) begin
      rdData = level_q;
    end else if (paddr == STATUS_ADDR) begin
      rdData = {frameCount_q, 14'h0000, link.lineValid, link.frameValid};
    end else begin
      rdData = 32'h0000_0000;
      mapped = 1'b0;
    end
  end

  assign prdata = rdData;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RST;
      window_q <= WINDOW_RST;
      size_q <= SIZE_RST;
      level_q <= {8'h00, PIVOT_RST, BLACK_RST, OFFSET_RST};
    end else if (wrEn) begin
      if (paddr == CTRL_ADDR) begin
        ctrl_q <= {22'h000000, pwdata[9:0]};
      end else if (paddr == WINDOW_ADDR) begin
        window_q <= {7'h00, pwdata[24:16], 6'h00, pwdata[9:0]};
      end else if (paddr == SIZE_ADDR) begin
        size_q <= {7'h00, pwdata[24:16], 6'h00, pwdata[9:0]};
      end else if (paddr == LEVEL_ADDR) begin
        level_q <= {8'h00, pwdata[23:0]};
      end
    end
  end

  // master clock as an enable pulse; the sensor is held in reset until run is set
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_q <= '0;
    end else if (divCnt_q == 8'(PIX_DIV - 1)) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + 1'b1;
    end
  end

  assign link.pixClkEn = (divCnt_q == 8'(PIX_DIV - 1));
  assign link.sensorReset_n = ctrl_q[CTRL_RUN];
  assign link.subsample = ctrl_q[CTRL_SUB];
  assign link.granularitySelect = ctrl_q[CTRL_GRAN_LO +: 2];
  assign link.ampUnitySelect = ctrl_q[CTRL_UNITY];
  assign link.preDivideBypass = ctrl_q[CTRL_BYPASS];
  assign link.ampGainCode = ctrl_q[CTRL_GAIN_LO +: 4];
  assign link.windowColStart = window_q[COL_W-1:0];
  // subsampling only addresses even rows
  assign link.windowRowStart = window_q[HI_FIELD_LO +: ROW_W] & {8'hff, !ctrl_q[CTRL_SUB]};
  assign link.windowWidthCount = size_q[COL_W-1:0];
  assign link.frameLineTimer = size_q[HI_FIELD_LO +: ROW_W];
  assign link.offsetLevel = level_q[7:0];
  assign link.blackLevel = level_q[LEVEL_BLACK_LO +: 8];
  assign link.pivotLevel = level_q[LEVEL_PIVOT_LO +: 8];

  // capture pixels and count finished frames
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pixelOut_q <= '0;
      pixelOutValid_q <= 1'b0;
      frameSeen_q <= 1'b0;
      frameCount_q <= '0;
    end else begin
      pixelOutValid_q <= link.lineValid && link.pixClkEn;
      if (link.lineValid && link.pixClkEn) begin
        pixelOut_q <= link.pixelData;
      end
      frameSeen_q <= link.frameValid;
      if (frameSeen_q && !link.frameValid) begin
        frameCount_q <= frameCount_q + 1'b1;
      end
    end
  end

  assign pixelOut = pixelOut_q;
  assign pixelOutValid = pixelOutValid_q;
  assign frameActive = frameSeen_q;
endmodule // camera_controller_end
`default_nettype wire

// ===== image_readout_assertions.sv
// Purpose: concurrent checks on the sensor-controller link
// Assumes: PIX_DIV=1, so one master period is one ref_clk cycle
// Notes: settings are held steady while the sensor runs
`timescale 1ns/1ps
`default_nettype none
module image_readout_assertions
  import image_readout_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // link signals
  input wire logic sensorReset_n,
  input wire logic [1:0] granularitySelect,
  input wire logic subsample,
  input wire logic [COL_W-1:0] windowWidthCount,
  input wire logic [ROW_W-1:0] frameLineTimer,
  input wire logic lineValid,
  input wire logic frameValid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [11:0] runQ;
  logic [11:0] gapQ;
  logic [11:0] lowQ;
  logic [9:0] lineQ;
  logic seenQ;
  logic [11:0] fotExp;
  logic [11:0] rotBase;
  logic [11:0] rotExp;
  always_comb begin
    case (granularitySelect)
      2'b11: fotExp = 12'd1200;
      2'b10: fotExp = 12'd624;
      2'b01: fotExp = 12'd336;
      default: fotExp = 12'd192;
    endcase
  end
  always_comb begin
    case (granularitySelect)
      2'b11: rotBase = 12'd48;
      2'b10: rotBase = 12'd32;
      2'b01: rotBase = 12'd24;
      default: rotBase = 12'd20;
    endcase
  end
  assign rotExp = subsample ? rotBase + 12'd8 : rotBase;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) runQ <= '0;
    else runQ <= lineValid ? runQ + 12'd1 : '0;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) gapQ <= '0;
    else gapQ <= (frameValid && !lineValid) ? gapQ + 12'd1 : '0;
  end
  // low time only counts once a whole frame was seen, the first gap is start-up
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) lowQ <= '0;
    else lowQ <= (frameValid || !sensorReset_n) ? '0 : lowQ + 12'd1;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) seenQ <= 1'b0;
    else seenQ <= !sensorReset_n ? 1'b0 : (frameValid | seenQ);
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) lineQ <= '0;
    else lineQ <= !frameValid ? '0 : lineQ + {9'd0, $rose(lineValid)};
  end
  AST_LV_IN_FRAME: assert property (lineValid |-> frameValid)
    else $error("line valid outside frame");
  AST_QUIET_IN_RESET: assert property (!sensorReset_n [*2] |-> !lineValid && !frameValid)
    else $error("stream active while sequencer held");
  AST_LINE_WIDTH: assert property ($fell(lineValid) && sensorReset_n |->
    runQ == {2'b00, windowWidthCount[COL_W-1:3], 3'b000})
    else $error("line length wrong");
  AST_ROW_OVERHEAD: assert property ($rose(lineValid) |-> gapQ == rotExp)
    else $error("row overhead wrong");
  AST_FRAME_OVERHEAD: assert property ($rose(frameValid) && seenQ |-> lowQ == fotExp)
    else $error("frame overhead wrong");
  AST_LINE_COUNT: assert property ($fell(frameValid) && sensorReset_n |->
    lineQ == {1'b0, frameLineTimer})
    else $error("line count wrong");
  AST_START_DELAY: assert property ($rose(sensorReset_n) |=> !frameValid [*8])
    else $error("frame began without overhead");
  AST_FRAME_MIN: assert property ($rose(frameValid) |-> frameValid [*8])
    else $error("frame valid too short");
  cover property ($rose(frameValid) && seenQ);
  cover property ($fell(lineValid) && subsample);
  cover property ($fell(frameValid) && granularitySelect == 2'b11);
endmodule // image_readout_assertions
`default_nettype wire

// ===== image_readout_if.sv
// Purpose: link between the image sensor sequencer and its camera controller
// Assumes: both ends run on the same reference clock
// Notes: configuration travels as parallel levels; serial framing is not modelled
`timescale 1ns/1ps
`default_nettype none
interface image_readout_if;
  import image_readout_pkg::*;

  logic pixClkEn;
  logic sensorReset_n;
  logic [1:0] granularitySelect;
  logic subsample;
  logic [COL_W-1:0] windowColStart;
  logic [ROW_W-1:0] windowRowStart;
  logic [COL_W-1:0] windowWidthCount;
  logic [ROW_W-1:0] frameLineTimer;
  logic [3:0] ampGainCode;
  logic ampUnitySelect;
  logic preDivideBypass;
  logic [7:0] offsetLevel;
  logic [7:0] blackLevel;
  logic [7:0] pivotLevel;
  logic [PIX_W-1:0] pixelData;
  logic lineValid;
  logic frameValid;

  modport sensor (
    input pixClkEn, sensorReset_n, granularitySelect, subsample, windowColStart,
    input windowRowStart, windowWidthCount, frameLineTimer, ampGainCode, ampUnitySelect,
    input preDivideBypass, offsetLevel, blackLevel, pivotLevel,
    output pixelData, lineValid, frameValid
  );

  modport controller (
    output pixClkEn, sensorReset_n, granularitySelect, subsample, windowColStart,
    output windowRowStart, windowWidthCount, frameLineTimer, ampGainCode, ampUnitySelect,
    output preDivideBypass, offsetLevel, blackLevel, pivotLevel,
    input pixelData, lineValid, frameValid
  );
endinterface
`default_nettype wire

// ===== image_readout_pkg.sv
// Purpose: shared constants for the image readout sequencer and its controller
// Assumes: one 250 MHz reference clock drives both ends
// Notes: all counts are in master clock periods unless named otherwise
package image_readout_pkg;

  // array geometry
  localparam int ARRAY_COLS = 640;
  localparam int ARRAY_ROWS = 480;
  localparam int COL_W = 10;
  localparam int ROW_W = 9;
  localparam int PIX_W = 10;
  localparam int COL_GRANULE_BITS = 3;
  localparam int KERNEL_PIX = 4;

  // clocking
  localparam int REF_CLK_PERIOD_PS = 4000;
  localparam int MASTER_CLK_PERIOD_PS = 12500;
  localparam int MASTER_DIV = (MASTER_CLK_PERIOD_PS + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;

  // converter latency: 5.5 converter cycles, one converter cycle is four pixel periods
  localparam int ADC_LATENCY_HALF_CYCLES = 11;
  localparam int ADC_LATENCY_PIX = ADC_LATENCY_HALF_CYCLES * KERNEL_PIX / 2;

  // overhead times
  localparam logic [10:0] FOT_GRAN3 = 11'd1200;
  localparam logic [10:0] FOT_GRAN2 = 11'd624;
  localparam logic [10:0] FOT_GRAN1 = 11'd336;
  localparam logic [10:0] FOT_GRAN0 = 11'd192;
  localparam logic [10:0] ROT_GRAN3 = 11'd48;
  localparam logic [10:0] ROT_GRAN2 = 11'd32;
  localparam logic [10:0] ROT_GRAN1 = 11'd24;
  localparam logic [10:0] ROT_GRAN0 = 11'd20;
  localparam logic [10:0] ROT_SUBSAMPLE_EXTRA = 11'd8;

  // gain arithmetic in Q8
  localparam int GAIN_FRAC = 8;
  localparam logic [11:0] GAIN_UNITY = 12'h100;

  // controller register map (byte addresses)
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] WINDOW_ADDR = 8'h04;
  localparam logic [7:0] SIZE_ADDR = 8'h08;
  localparam logic [7:0] LEVEL_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h10;

  // field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SUB = 1;
  localparam int CTRL_GRAN_LO = 2;
  localparam int CTRL_UNITY = 4;
  localparam int CTRL_BYPASS = 5;
  localparam int CTRL_GAIN_LO = 6;
  localparam int HI_FIELD_LO = 16;
  localparam int LEVEL_BLACK_LO = 8;
  localparam int LEVEL_PIVOT_LO = 16;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0008;
  localparam logic [31:0] WINDOW_RST = 32'h0000_0000;
  localparam logic [31:0] SIZE_RST = 32'h01e0_0280;
  localparam logic [7:0] OFFSET_RST = 8'h64;
  localparam logic [7:0] BLACK_RST = 8'h00;
  localparam logic [7:0] PIVOT_RST = 8'hff;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FOT = 2'b01,
    SEQ_ROT = 2'b11,
    SEQ_LINE = 2'b10
  } seq_state_type;

  function automatic logic [10:0] frameOverhead(input logic [1:0] gran);
    case (gran)
      2'b11: frameOverhead = FOT_GRAN3;
      2'b10: frameOverhead = FOT_GRAN2;
      2'b01: frameOverhead = FOT_GRAN1;
      default: frameOverhead = FOT_GRAN0;
    endcase
  endfunction

  function automatic logic [10:0] rowOverhead(input logic [1:0] gran, input logic sub);
    logic [10:0] base;
    case (gran)
      2'b11: base = ROT_GRAN3;
      2'b10: base = ROT_GRAN2;
      2'b01: base = ROT_GRAN1;
      default: base = ROT_GRAN0;
    endcase
    rowOverhead = sub ? base + ROT_SUBSAMPLE_EXTRA : base;
  endfunction

  function automatic logic [11:0] gainStep(input logic [3:0] code);
    case (code)
      4'h0: gainStep = 12'h152;
      4'h1: gainStep = 12'h18f;
      4'h2: gainStep = 12'h1da;
      4'h3: gainStep = 12'h22e;
      4'h4: gainStep = 12'h294;
      4'h5: gainStep = 12'h30d;
      4'h6: gainStep = 12'h397;
      4'h7: gainStep = 12'h438;
      4'h8: gainStep = 12'h4e6;
      4'h9: gainStep = 12'h5d7;
      4'ha: gainStep = 12'h6d7;
      4'hb: gainStep = 12'h805;
      4'hc: gainStep = 12'h961;
      4'hd: gainStep = 12'hb33;
      4'he: gainStep = 12'hd1f;
      default: gainStep = 12'hf61;
    endcase
  endfunction

endpackage

// ===== image_readout_sequencer_tb_top.sv
// Purpose: apb driven test of controller and sensor ends together
// Assumes: PIX_DIV=1 and short pipeline, so periods count ref_clk cycles
// Notes: frames are measured between rises of frameActive
`timescale 1ns/1ps
`default_nettype none
module image_readout_sequencer_tb_top;
  import image_readout_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [PIX_W-1:0] pixelOut;
  logic pixelOutValid;
  logic frameActive;
  logic frameDone;
  logic actQ = 1'b0;
  logic [31:0] q;
  logic e;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0, px = 0, dn = 0, lastCyc = 0, lastPx = 0, lastDn = 0, frames = 0;
  int fotTab[4] = '{192, 336, 624, 1200};
  int rotTab[4] = '{20, 24, 32, 48};
  always #2 ref_clk = ~ref_clk;
  image_readout_if link();
  camera_controller_end #(.PIX_DIV(1)) camera_controller_end_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixelOut(pixelOut), .pixelOutValid(pixelOutValid), .frameActive(frameActive), .link(link));
  image_sensor_end #(.PIPE_DEPTH(4), .COLOUR(1'b1)) image_sensor_end_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .link(link), .scanRow(), .frameDone(frameDone));
  image_readout_assertions image_readout_assertions_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .sensorReset_n(link.sensorReset_n), .granularitySelect(link.granularitySelect),
    .subsample(link.subsample), .windowWidthCount(link.windowWidthCount),
    .frameLineTimer(link.frameLineTimer), .lineValid(link.lineValid),
    .frameValid(link.frameValid));
  // per-frame monitor: period, pixel and done counts between frame starts
  always @(posedge ref_clk) begin
    actQ <= frameActive;
    cyc <= cyc + 1;
    px <= px + int'(pixelOutValid === 1'b1);
    dn <= dn + int'(frameDone === 1'b1);
    if (frameActive === 1'b1 && actQ !== 1'b1) begin
      lastCyc <= cyc;
      lastPx <= px;
      lastDn <= dn;
      cyc <= 1;
      px <= 0;
      dn <= 0;
      frames <= frames + 1;
    end
  end
  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // waits for pready rather than assuming zero wait states
  task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apbXfer(1'b0, a, 32'h0);
    check(q, exp, what);
  endtask
  task automatic waitFrames(input int k);
    int f0;
    f0 = frames;
    while (frames < f0 + k) begin
      @(posedge ref_clk);
    end
    // a frame cut short by clearing run would trip the minimum frame length check
    repeat (8) @(posedge ref_clk);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdChk(CTRL_ADDR, CTRL_RST, "ctrl reset");
    rdChk(WINDOW_ADDR, WINDOW_RST, "window reset");
    rdChk(SIZE_ADDR, SIZE_RST, "size reset");
    rdChk(LEVEL_ADDR, {8'h00, PIVOT_RST, BLACK_RST, OFFSET_RST}, "level reset");
    apbXfer(1'b0, 8'h14, 32'h0);
    check(q, 32'h0, "unmapped data");
    check(32'(e), 32'h1, "unmapped error");
    apbXfer(1'b1, CTRL_ADDR, 32'hffff_fc00);
    rdChk(CTRL_ADDR, 32'h0, "ctrl unused bits");
    apbXfer(1'b1, LEVEL_ADDR, 32'h00a5_1e80);
    @(negedge ref_clk);
    check(32'({link.offsetLevel, link.blackLevel}), 32'h801e, "offset levels");
    check(32'(link.pivotLevel), 32'ha5, "pivot level");
    // gain code sweep, unity and bypass toggled along the way
    for (int g = 0; g < 16; g++) begin
      apbXfer(1'b1, CTRL_ADDR, (32'(g) << CTRL_GAIN_LO) | 32'(g & 3) << CTRL_UNITY);
      @(negedge ref_clk);
      check(32'({link.ampGainCode, link.preDivideBypass, link.ampUnitySelect}),
        32'({g[3:0], g[1], g[0]}), "gain settings");
    end
    apbXfer(1'b1, CTRL_ADDR, 32'h2);
    apbXfer(1'b1, WINDOW_ADDR, 32'h0005_0010);
    @(negedge ref_clk);
    check(32'(link.windowRowStart), 32'h4, "subsample row start");
    check(32'(link.windowColStart), 32'h10, "column start");
    check(32'(link.sensorReset_n), 32'h0, "sensor held");
    // every granularity, subsampling on odd codes; width 20 rounds to 16
    for (int i = 0; i < 4; i++) begin
      apbXfer(1'b1, CTRL_ADDR, (32'(i) << CTRL_GRAN_LO) | (32'(i & 1) << CTRL_SUB));
      apbXfer(1'b1, WINDOW_ADDR, 32'h0002_0008);
      apbXfer(1'b1, SIZE_ADDR, 32'h0003_0014);
      apbXfer(1'b1, CTRL_ADDR, (32'(i) << CTRL_GRAN_LO) | (32'(i & 1) << CTRL_SUB) | 32'h1);
      waitFrames(3);
      check(32'(lastCyc), 32'(fotTab[i] + 3 * (rotTab[i] + 8 * (i & 1) + 16)), "frame");
      check(32'(lastPx), 32'd48, "pixels per frame");
      check(32'(lastDn), 32'd1, "frame done pulses");
      check(32'(pixelOut), (i & 1) ? 32'd300 : 32'd301, "last pixel level");
    end
    test_done();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end
endmodule // image_readout_sequencer_tb_top
`default_nettype wire

// ===== image_sensor_end.sv
// Purpose: readout sequencer and pixel output path of the sensor end
// Assumes: link inputs come from logic on ref_clk; pixClkEn paces master clock periods
// Notes: pixel levels are a synthetic pattern standing in for the analog array
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - loaded window read progressively, line after line
// - columns in eight-pixel granules, rows single lines
// - scan starts at loaded column and row
// - width from width setting, lines from timer
// - four converters sampled per kernel, interleaved
// - frame is overhead plus rows of overhead+pixels
// - frame overhead 1200/624/336/192 by granularity
// - row overhead 48/32/24/20 by granularity
// - subsampling adds eight periods per row overhead
// - controller uses even rows when subsampling
// - results appear 5.5 converter cycles after sampling
// - offset equals offset level minus black level
// - default offset 200 mV, 340 mV recommended
// - four-bit code selects sixteen gain steps
// - unity select overrides the gain code
// - pre-divide halves signal unless bypassed
// - gain pivots about the calibration level
// - red filter sits on pixel zero zero
// - line valid marks valid pixel cycles
// - frame valid high during frame readout
// - controller drives reset and master clock
module image_sensor_end
  import image_readout_pkg::*;
#(
  parameter int PIPE_DEPTH = ADC_LATENCY_PIX,
  parameter bit COLOUR = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // link to the controller
  image_readout_if.sensor link,
  // scan observation
  output logic [ROW_W-1:0] scanRow,
  output logic frameDone
);
  if (PIPE_DEPTH < 1) begin : gBadDepth
    $error("PIPE_DEPTH must be at least one");
  end

  seq_state_type state_q;
  logic [10:0] ovhCnt_q;
  logic [COL_W-1:0] pixCnt_q;
  logic [ROW_W-1:0] lineCnt_q;
  logic [ROW_W-1:0] rowAddr_q;
  logic inFrame_q;
  logic frameDone_q;
  logic [1:0] granQ;
  logic subQ;
  logic [COL_W-1:0] colStartQ;
  logic [ROW_W-1:0] rowStartQ;
  logic [COL_W-1:0] widthQ;
  logic [ROW_W-1:0] linesQ;
  logic emitLine_q;
  logic emitFrame_q;
  logic [1:0] emitPhase_q;
  logic [PIX_W-1:0] convCode [KERNEL_PIX];
  logic [PIX_W+1:0] pipe_q [PIPE_DEPTH];
  logic step;
  logic latchCfg;
  logic lastPix;
  logic lastLine;
  logic kernelStart;

  assign step = link.pixClkEn;
  assign lastPix = (pixCnt_q == widthQ - 1'b1);
  assign lastLine = (lineCnt_q == linesQ - 1'b1);
  assign latchCfg = step && (state_q == SEQ_IDLE || (state_q == SEQ_LINE && lastPix && lastLine));
  assign kernelStart = step && state_q == SEQ_LINE && pixCnt_q[1:0] == 2'b00;

  // synthetic array level, red sites biased so the mosaic phase is visible
  function automatic logic [PIX_W-1:0] arrayLevel(input logic [ROW_W-1:0] row,
                                                  input logic [COL_W-1:0] col);
    logic [PIX_W-1:0] base;
    base = col ^ {1'b0, row};
    if (COLOUR && !row[0] && !col[0]) begin
      base = base | 10'h200;
    end
    arrayLevel = base;
  endfunction

  // configuration is taken at each frame start so a frame is never mixed
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      granQ <= 2'b00;
      subQ <= 1'b0;
      colStartQ <= '0;
      rowStartQ <= '0;
      widthQ <= SIZE_RST[COL_W-1:0];
      linesQ <= SIZE_RST[HI_FIELD_LO +: ROW_W];
    end else if (latchCfg) begin
      granQ <= link.granularitySelect;
      subQ <= link.subsample;
      colStartQ <= {link.windowColStart[COL_W-1:COL_GRANULE_BITS], 3'b000};
      rowStartQ <= link.windowRowStart;
      widthQ <= {link.windowWidthCount[COL_W-1:COL_GRANULE_BITS], 3'b000};
      linesQ <= link.frameLineTimer;
    end
  end

  // readout sequencer: overhead, then rows of overhead plus pixels
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SEQ_IDLE;
      ovhCnt_q <= '0;
      pixCnt_q <= '0;
      lineCnt_q <= '0;
      rowAddr_q <= '0;
      inFrame_q <= 1'b0;
      frameDone_q <= 1'b0;
    end else if (!link.sensorReset_n) begin
      state_q <= SEQ_IDLE;
      inFrame_q <= 1'b0;
      frameDone_q <= 1'b0;
    end else begin
      frameDone_q <= 1'b0;
      if (step) begin
        case (state_q)
          SEQ_IDLE: begin
            state_q <= SEQ_FOT;
            ovhCnt_q <= frameOverhead(link.granularitySelect) - 1'b1;
          end
          SEQ_FOT: begin
            if (ovhCnt_q == '0) begin
              state_q <= SEQ_ROT;
              ovhCnt_q <= rowOverhead(granQ, subQ) - 1'b1;
              lineCnt_q <= '0;
              rowAddr_q <= rowStartQ;
              inFrame_q <= 1'b1;
            end else begin
              ovhCnt_q <= ovhCnt_q - 1'b1;
            end
          end
          SEQ_ROT: begin
            if (ovhCnt_q == '0) begin
              state_q <= SEQ_LINE;
              pixCnt_q <= '0;
            end else begin
              ovhCnt_q <= ovhCnt_q - 1'b1;
            end
          end
          default: begin
            if (lastPix) begin
              if (lastLine) begin
                state_q <= SEQ_FOT;
                ovhCnt_q <= frameOverhead(link.granularitySelect) - 1'b1;
                inFrame_q <= 1'b0;
                frameDone_q <= 1'b1;
              end else begin
                state_q <= SEQ_ROT;
                ovhCnt_q <= rowOverhead(granQ, subQ) - 1'b1;
                lineCnt_q <= lineCnt_q + 1'b1;
                rowAddr_q <= rowAddr_q + (subQ ? 9'd2 : 9'd1);
              end
            end else begin
              pixCnt_q <= pixCnt_q + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // four converters sample one kernel of adjacent pixels together
  for (genvar k = 0; k < KERNEL_PIX; k++) begin : gConv
    pixel_conditioner uConv (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .sampleEn(kernelStart),
      .rawLevel(arrayLevel(rowAddr_q, colStartQ + pixCnt_q + COL_W'(k))),
      .offsetLevel(link.offsetLevel),
      .blackLevel(link.blackLevel),
      .pivotLevel(link.pivotLevel),
      .ampGainCode(link.ampGainCode),
      .ampUnitySelect(link.ampUnitySelect),
      .preDivideBypass(link.preDivideBypass),
      .sampleCode(convCode[k])
    );
  end

  // interleave phase follows the pixel that was sampled one period earlier
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      emitLine_q <= 1'b0;
      emitFrame_q <= 1'b0;
      emitPhase_q <= 2'b00;
    end else if (step) begin
      emitLine_q <= (state_q == SEQ_LINE) && link.sensorReset_n;
      // same stage as the line flag, else the last pixel falls outside the frame
      emitFrame_q <= inFrame_q;
      emitPhase_q <= pixCnt_q[1:0];
    end
  end

  // converter latency: flags travel with the data so valid lines stay aligned
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= '0;
      end
    end else if (!link.sensorReset_n) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= '0;
      end
    end else if (step) begin
      pipe_q[0] <= {emitFrame_q, emitLine_q, convCode[emitPhase_q]};
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  assign link.pixelData = pipe_q[PIPE_DEPTH-1][PIX_W-1:0];
  assign link.lineValid = pipe_q[PIPE_DEPTH-1][PIX_W];
  assign link.frameValid = pipe_q[PIPE_DEPTH-1][PIX_W+1];
  assign scanRow = rowAddr_q;
  assign frameDone = frameDone_q;
endmodule // image_sensor_end
`default_nettype wire

// ===== pixel_conditioner.sv
// Purpose: offset and gain conditioning of one converter's sample
// Assumes: levels are in converter codes, pivot scaled from 8 to 10 bits
// Notes: result is clamped to the converter range and held until the next sample
`timescale 1ns/1ps
`default_nettype none
module pixel_conditioner
  import image_readout_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // sample strobe and level
  input wire logic sampleEn,
  input wire logic [PIX_W-1:0] rawLevel,
  // analog settings
  input wire logic [7:0] offsetLevel,
  input wire logic [7:0] blackLevel,
  input wire logic [7:0] pivotLevel,
  input wire logic [3:0] ampGainCode,
  input wire logic ampUnitySelect,
  input wire logic preDivideBypass,
  // converted code
  output logic [PIX_W-1:0] sampleCode
);
  logic [11:0] gain;
  logic signed [13:0] shifted;
  logic signed [13:0] pivot;
  logic signed [27:0] amplified;
  logic signed [27:0] level;
  logic [PIX_W-1:0] sampleCode_d;

  always_comb begin
    gain = ampUnitySelect ? GAIN_UNITY : gainStep(ampGainCode);
    if (!preDivideBypass) begin
      gain = {1'b0, gain[11:1]};
    end
    shifted = $signed({4'h0, rawLevel}) + $signed({6'h00, offsetLevel})
      - $signed({6'h00, blackLevel});
    pivot = $signed({4'h0, pivotLevel, 2'b00});
    amplified = (shifted - pivot) * $signed({2'b00, gain});
    level = (amplified >>> GAIN_FRAC) + 28'(pivot);
    if (level < 0) begin
      sampleCode_d = '0;
    end else if (level > 28'sd1023) begin
      sampleCode_d = '1;
    end else begin
      sampleCode_d = level[PIX_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sampleCode <= '0;
    end else if (sampleEn) begin
      sampleCode <= sampleCode_d;
    end
  end
endmodule // pixel_conditioner
`default_nettype wire
